/* rtl/cas_pkg.sv */
/*
 * Constants, register map and field layout of the cell alert status
 * register bank. Assumes one 10 MHz system clock and an internal register
 * port that carries a one-cycle read or write strobe with a 5-bit address.
 */
// Operation
// - General status bits fifteen to two read as zero and writes to them are dropped.
// - General status bit one is set when the second auxiliary input is past a temperature limit.
// - General status bit zero is set when the first auxiliary input is past a temperature limit.
// - An auxiliary fault flag clears itself when a later measurement shows no fault.
// - A software write of one to an auxiliary fault flag leaves it unchanged.
// - The summary register holds one alert flag per cell in bits eleven to zero, cell one at bit zero.
// - Each summary bit is the OR of the matching overvoltage and undervoltage bits.
// - Summary bits fifteen to twelve read as zero and ignore writes.
// - The overvoltage register sets a cell's bit when its measurement exceeds the overvoltage limit.
// - Every per-cell alert bit returns to zero once its condition is gone.
// - Overvoltage register bits fifteen to twelve read as zero and ignore writes.
// - Over-temperature is a reading below its threshold, under-temperature a reading above its threshold.
// - The undervoltage register sets a cell's bit when its measurement is below the undervoltage limit; here it has no read address.
package cas_pkg;

    // ==========================================================
    // Geometry
    localparam int unsigned NUM_CELLS   = 12;
    localparam int unsigned DATA_W      = 12;
    localparam int unsigned REG_W       = 16;
    localparam int unsigned ADDR_W      = 5;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_GENERAL_STATUS  = 5'h02;
    localparam logic [ADDR_W-1:0] ADDR_ALERT_SUMMARY   = 5'h03;
    localparam logic [ADDR_W-1:0] ADDR_OV_ALERT        = 5'h04;

    // ==========================================================
    // Field positions
    localparam int unsigned BIT_AUX_A_FAULT = 0;
    localparam int unsigned BIT_AUX_B_FAULT = 1;
    localparam int unsigned CELL_MSB        = 11;

    // ==========================================================
    // Reset values
    localparam logic [NUM_CELLS-1:0] CELL_FLAGS_RESET = 12'h000;
    localparam logic [1:0]           AUX_FLAGS_RESET  = 2'h0;
    localparam logic [REG_W-1:0]     READ_DATA_RESET  = 16'h0000;

endpackage

/* rtl/cas_cmp_if.sv */
/*
 * Carrier between the top and the comparator: raw measurements and
 * limits in, raw comparison results out. Same clock domain on both ends.
 */
`timescale 1ns/1ns
`default_nettype none
interface cas_cmp_if;
    import cas_pkg::*;

    logic [NUM_CELLS*DATA_W-1:0] cell_data;
    logic [DATA_W-1:0]           ov_limit;
    logic [DATA_W-1:0]           uv_limit;
    logic [DATA_W-1:0]           aux_a;
    logic [DATA_W-1:0]           aux_b;
    logic [DATA_W-1:0]           ot_limit;
    logic [DATA_W-1:0]           ut_limit;
    logic [NUM_CELLS-1:0]        ov_hit;
    logic [NUM_CELLS-1:0]        uv_hit;
    logic [1:0]                  aux_hit;

    modport top (output cell_data, ov_limit, uv_limit, aux_a, aux_b,
                 ot_limit, ut_limit, input ov_hit, uv_hit, aux_hit);
    modport cmp (input cell_data, ov_limit, uv_limit, aux_a, aux_b,
                 ot_limit, ut_limit, output ov_hit, uv_hit, aux_hit);
endinterface
`default_nettype wire

/* rtl/cas_compare.sv */
/*
 * Purely combinational threshold comparison of one scan's results.
 * Assumes inputs are stable while the scan-done strobe is high.
 */
`timescale 1ns/1ns
`default_nettype none
module cas_compare
    import cas_pkg::*;
(
    cas_cmp_if.cmp cmp
);
    always_comb
    begin
        for (int i = 0; i < NUM_CELLS; i++)
        begin
            cmp.ov_hit[i] = cmp.cell_data[i*DATA_W +: DATA_W] > cmp.ov_limit;
            cmp.uv_hit[i] = cmp.cell_data[i*DATA_W +: DATA_W] < cmp.uv_limit;
        end
        // NTC thermistor: hot means a low reading, cold a high one
        cmp.aux_hit[BIT_AUX_A_FAULT] = (cmp.aux_a < cmp.ot_limit)
                                     | (cmp.aux_a > cmp.ut_limit);
        cmp.aux_hit[BIT_AUX_B_FAULT] = (cmp.aux_b < cmp.ot_limit)
                                     | (cmp.aux_b > cmp.ut_limit);
    end
endmodule
`default_nettype wire

/* rtl/cas_alert_regs.sv */
/*
 * Top of the cell alert status register bank: flags updated at each scan
 * completion, all but the undervoltage flags read through the internal register port.
 * Assumes scan results come from logic on sys_clk_in, so they need no
 * synchroniser, and that the register port strobes last one cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module cas_alert_regs
    import cas_pkg::*;
(
    // Clock and reset
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_n_in,
    // Scan results
    input  wire logic                        scan_done_in,
    input  wire logic [NUM_CELLS*DATA_W-1:0] cell_data_in,
    input  wire logic [DATA_W-1:0]           aux_input_a_in,
    input  wire logic [DATA_W-1:0]           aux_input_b_in,
    // Limits
    input  wire logic [DATA_W-1:0]           ov_limit_in,
    input  wire logic [DATA_W-1:0]           uv_limit_in,
    input  wire logic [DATA_W-1:0]           over_temp_threshold_in,
    input  wire logic [DATA_W-1:0]           under_temp_threshold_in,
    // Register port
    input  wire logic                        reg_rd_in,
    input  wire logic                        reg_wr_in,
    input  wire logic [ADDR_W-1:0]           reg_addr_in,
    input  wire logic [REG_W-1:0]            reg_wdata_in,
    output logic      [REG_W-1:0]            reg_rdata_out,
    output logic                             reg_rvalid_out,
    // Flag views
    output logic      [NUM_CELLS-1:0]        per_cell_overvoltage_alert_out,
    output logic      [NUM_CELLS-1:0]        per_cell_undervoltage_alert_out,
    output logic      [NUM_CELLS-1:0]        per_cell_alert_summary_out,
    output logic                             aux_input_a_fault_out,
    output logic                             aux_input_b_fault_out
);
    cas_cmp_if cmp_bus();

    logic [NUM_CELLS-1:0] ov_flags;
    logic [NUM_CELLS-1:0] uv_flags;
    logic [NUM_CELLS-1:0] sum_flags;
    logic [1:0]           aux_flags;
    logic [NUM_CELLS-1:0] next_ov_flags;
    logic [NUM_CELLS-1:0] next_uv_flags;
    logic [NUM_CELLS-1:0] next_sum_flags;
    logic [1:0]           next_aux_flags;
    logic [REG_W-1:0]     rdata;
    logic                 rvalid;
    logic [REG_W-1:0]     next_rdata;
    logic                 next_rvalid;

    assign cmp_bus.cell_data = cell_data_in;
    assign cmp_bus.ov_limit  = ov_limit_in;
    assign cmp_bus.uv_limit  = uv_limit_in;
    assign cmp_bus.aux_a     = aux_input_a_in;
    assign cmp_bus.aux_b     = aux_input_b_in;
    assign cmp_bus.ot_limit  = over_temp_threshold_in;
    assign cmp_bus.ut_limit  = under_temp_threshold_in;

    cas_compare u_compare
    (
        .cmp (cmp_bus.cmp)
    );

    // ==========================================================
    // Alert flags
    // Flags mirror the last completed scan only; nothing latches, so a
    // transient fault shorter than one scan is never seen.
    always_comb
    begin
        next_ov_flags  = ov_flags;
        next_uv_flags  = uv_flags;
        next_sum_flags = sum_flags;
        next_aux_flags = aux_flags;
        if (scan_done_in)
        begin
            next_ov_flags  = cmp_bus.ov_hit;
            next_uv_flags  = cmp_bus.uv_hit;
            next_sum_flags = cmp_bus.ov_hit | cmp_bus.uv_hit;
            next_aux_flags = cmp_bus.aux_hit;
        end
        // Writes never reach the flags: no term of reg_wdata_in above
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ov_flags  <= CELL_FLAGS_RESET;
            uv_flags  <= CELL_FLAGS_RESET;
            sum_flags <= CELL_FLAGS_RESET;
            aux_flags <= AUX_FLAGS_RESET;
        end
        else
        begin
            ov_flags  <= next_ov_flags;
            uv_flags  <= next_uv_flags;
            sum_flags <= next_sum_flags;
            aux_flags <= next_aux_flags;
        end
    end

    // ==========================================================
    // Register read port
    // Only the bits owned here are driven on general status; upper bits
    // belong to other logic and read zero from this bank.
    always_comb
    begin
        next_rdata  = rdata;
        next_rvalid = 1'b0;
        if (reg_rd_in && !reg_wr_in)
        begin
            next_rvalid = 1'b1;
            next_rdata  = READ_DATA_RESET;
            unique case (reg_addr_in)
                ADDR_GENERAL_STATUS:
                begin
                    next_rdata[BIT_AUX_B_FAULT] = aux_flags[BIT_AUX_B_FAULT];
                    next_rdata[BIT_AUX_A_FAULT] = aux_flags[BIT_AUX_A_FAULT];
                end
                ADDR_ALERT_SUMMARY:
                    next_rdata[CELL_MSB:0] = sum_flags;
                ADDR_OV_ALERT:
                    next_rdata[CELL_MSB:0] = ov_flags;
                default:
                    next_rdata = READ_DATA_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata  <= READ_DATA_RESET;
            rvalid <= 1'b0;
        end
        else
        begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    assign reg_rdata_out                   = rdata;
    assign reg_rvalid_out                  = rvalid;
    assign per_cell_overvoltage_alert_out  = ov_flags;
    assign per_cell_undervoltage_alert_out = uv_flags;
    assign per_cell_alert_summary_out      = sum_flags;
    assign aux_input_a_fault_out           = aux_flags[BIT_AUX_A_FAULT];
    assign aux_input_b_fault_out           = aux_flags[BIT_AUX_B_FAULT];
endmodule
`default_nettype wire

/* tb/cas_alert_regs_chk.sv */
/* Checker for the alert register bank top ports.
   Assumes one clock domain and the bank's one-cycle read answer. */
`timescale 1ns/1ns
`default_nettype none
module cas_alert_regs_chk
    import cas_pkg::*;
(
    input wire logic                        sys_clk_in, rst_n_in, scan_done_in,
    input wire logic [NUM_CELLS*DATA_W-1:0] cell_data_in,
    input wire logic [DATA_W-1:0]           aux_input_a_in, aux_input_b_in,
    input wire logic [DATA_W-1:0]           ov_limit_in, uv_limit_in,
    input wire logic [DATA_W-1:0]           over_temp_threshold_in, under_temp_threshold_in,
    input wire logic                        reg_rd_in, reg_wr_in, reg_rvalid_out,
    input wire logic [ADDR_W-1:0]           reg_addr_in,
    input wire logic [REG_W-1:0]            reg_rdata_out,
    input wire logic [NUM_CELLS-1:0]        per_cell_overvoltage_alert_out,
    input wire logic [NUM_CELLS-1:0]        per_cell_undervoltage_alert_out,
    input wire logic [NUM_CELLS-1:0]        per_cell_alert_summary_out,
    input wire logic                        aux_input_a_fault_out, aux_input_b_fault_out
);
    wire logic [NUM_CELLS-1:0] ov = per_cell_overvoltage_alert_out;
    wire logic [NUM_CELLS-1:0] uv = per_cell_undervoltage_alert_out;
    wire logic [NUM_CELLS-1:0] sm = per_cell_alert_summary_out;
    wire logic                 fa = aux_input_a_fault_out;
    wire logic                 fb = aux_input_b_fault_out;
    logic [NUM_CELLS-1:0] exp_ov, exp_uv;
    logic                 exp_fa, exp_fb;

    always_comb
    begin
        for (int i = 0; i < NUM_CELLS; i++)
        begin
            exp_ov[i] = cell_data_in[i*DATA_W +: DATA_W] > ov_limit_in;
            exp_uv[i] = cell_data_in[i*DATA_W +: DATA_W] < uv_limit_in;
        end
        // Thermistor input: a low reading means hot
        exp_fa = (aux_input_a_in < over_temp_threshold_in)
               | (aux_input_a_in > under_temp_threshold_in);
        exp_fb = (aux_input_b_in < over_temp_threshold_in)
               | (aux_input_b_in > under_temp_threshold_in);
    end

    // ==========================================================
    // Properties
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence scan_s;
        scan_done_in;
    endsequence
    sequence read_s(a);
        reg_rd_in && !reg_wr_in && reg_addr_in == a;
    endsequence

    sum_is_or_a: assert property (sm == (ov | uv))
        else $error("summary is not ov or uv");
    ov_update_a: assert property (scan_s |=> ov == $past(exp_ov))
        else $error("overvoltage flags wrong");
    uv_update_a: assert property (scan_s |=> uv == $past(exp_uv))
        else $error("undervoltage flags wrong");
    aux_a_update_a: assert property (scan_s |=> fa == $past(exp_fa))
        else $error("aux a fault wrong");
    aux_b_update_a: assert property (scan_s |=> fb == $past(exp_fb))
        else $error("aux b fault wrong");
    flags_hold_a: assert property (!scan_done_in |=> $stable({ov, uv, fa, fb}))
        else $error("flags moved without a scan");
    status_read_a: assert property (read_s(ADDR_GENERAL_STATUS) |=> reg_rvalid_out
        && reg_rdata_out == {14'h0, $past(fb), $past(fa)})
        else $error("status read wrong");
    summary_read_a: assert property (read_s(ADDR_ALERT_SUMMARY) |=> reg_rvalid_out
        && reg_rdata_out == {4'h0, $past(sm)})
        else $error("summary read wrong");
    ov_read_a: assert property (read_s(ADDR_OV_ALERT) |=> reg_rvalid_out
        && reg_rdata_out == {4'h0, $past(ov)})
        else $error("overvoltage read wrong");
    rvalid_once_a: assert property (!(reg_rd_in && !reg_wr_in) |=> !reg_rvalid_out)
        else $error("read valid without a read");
    rdata_hold_a: assert property (!(reg_rd_in && !reg_wr_in) |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
endmodule
bind cas_alert_regs cas_alert_regs_chk u_chk (.*);
`default_nettype wire

/* tb/cas_alert_regs_bench.sv */
/* Self-checking bench for the alert register bank.
   Assumes one-cycle strobes and a read answer one edge after the strobe. */
`timescale 1ns/1ns
`default_nettype none
module cas_alert_regs_bench
    import cas_pkg::*;
;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, scan_done_in = 1'b0;
    logic reg_rd_in = 1'b0, reg_wr_in = 1'b0;
    logic [NUM_CELLS*DATA_W-1:0] cell_data_in = '0;
    logic [DATA_W-1:0] aux_input_a_in = 12'h800, aux_input_b_in = 12'h800;
    logic [DATA_W-1:0] ov_limit_in = 12'h800, uv_limit_in = 12'h200;
    logic [DATA_W-1:0] over_temp_threshold_in = 12'h100, under_temp_threshold_in = 12'hE00;
    logic [ADDR_W-1:0] reg_addr_in = '0;
    logic [REG_W-1:0] reg_wdata_in = '0, reg_rdata_out;
    logic reg_rvalid_out, aux_input_a_fault_out, aux_input_b_fault_out;
    logic [NUM_CELLS-1:0] per_cell_overvoltage_alert_out, per_cell_undervoltage_alert_out;
    logic [NUM_CELLS-1:0] per_cell_alert_summary_out;
    int failures = 0, n_compared = 0;
    logic [DATA_W-1:0] ta [4] = '{12'h0FF, 12'h800, 12'h100, 12'h000};
    logic [DATA_W-1:0] tb [4] = '{12'h800, 12'hE01, 12'hE00, 12'hFFF};
    logic [1:0]        te [4] = '{2'h1, 2'h2, 2'h0, 2'h3};

    cas_alert_regs dut (.*);

    initial forever #50 sys_clk_in = ~sys_clk_in;

    // ==========================================================
    // Bus and compare tasks
    task automatic chk(input string what, input logic [REG_W-1:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic scan(input logic [NUM_CELLS*DATA_W-1:0] c, input logic [DATA_W-1:0] a, b);
        @(posedge sys_clk_in);
        cell_data_in <= c;
        aux_input_a_in <= a;
        aux_input_b_in <= b;
        scan_done_in <= 1'b1;
        @(posedge sys_clk_in);
        scan_done_in <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] exp);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk("read data", exp, reg_rdata_out);
        chk("read valid", 16'h0001, {15'h0, reg_rvalid_out});
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= 16'hFFFF;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_cells;
        // Cell 12 over, cell 3 under, cell 2 equal to its limit, cell 1 over
        scan({12'hFFF, {8{12'h500}}, 12'h1FF, 12'h800, 12'h801}, 12'h800, 12'h800);
        rd(ADDR_OV_ALERT, 16'h0801);
        rd(ADDR_ALERT_SUMMARY, 16'h0805);
        chk("uv flags", 16'h0004, {4'h0, per_cell_undervoltage_alert_out});
        wr(ADDR_ALERT_SUMMARY);
        wr(ADDR_OV_ALERT);
        rd(ADDR_ALERT_SUMMARY, 16'h0805);
        rd(5'h05, 16'h0000);
        // Read and write together is refused: no answer, data holds
        @(posedge sys_clk_in);
        reg_addr_in <= ADDR_OV_ALERT;
        reg_rd_in <= 1'b1;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        reg_wr_in <= 1'b0;
        #1;
        chk("refused valid", 16'h0000, {15'h0, reg_rvalid_out});
        chk("refused data", 16'h0000, reg_rdata_out);
        scan({12{12'h500}}, 12'h800, 12'h800);
        rd(ADDR_ALERT_SUMMARY, 16'h0000);
        rd(ADDR_OV_ALERT, 16'h0000);
        // Lower limit below every cell: all overvoltage
        @(posedge sys_clk_in);
        ov_limit_in <= 12'h400;
        scan({12{12'h500}}, 12'h800, 12'h800);
        rd(ADDR_OV_ALERT, 16'h0FFF);
        rd(ADDR_ALERT_SUMMARY, 16'h0FFF);
        @(posedge sys_clk_in);
        ov_limit_in <= 12'h800;
        $display("test cells done");
    endtask
    task automatic t_aux;
        for (int i = 0; i < 4; i++)
        begin
            scan({12{12'h500}}, ta[i], tb[i]);
            wr(ADDR_GENERAL_STATUS);
            rd(ADDR_GENERAL_STATUS, {14'h0, te[i]});
        end
        $display("test aux done");
    endtask
    task automatic t_reset;
        scan({12{12'hFFF}}, 12'h000, 12'h000);
        rd(ADDR_ALERT_SUMMARY, 16'h0FFF);
        rd(ADDR_GENERAL_STATUS, 16'h0003);
        @(posedge sys_clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("aux flags", 16'h0000, {14'h0, aux_input_b_fault_out, aux_input_a_fault_out});
        chk("summary flags", 16'h0000, {4'h0, per_cell_alert_summary_out});
        chk("uv flags", 16'h0000, {4'h0, per_cell_undervoltage_alert_out});
        rd(ADDR_GENERAL_STATUS, 16'h0000);
        rd(ADDR_ALERT_SUMMARY, 16'h0000);
        rd(ADDR_OV_ALERT, 16'h0000);
        $display("test mid reset done");
    endtask

    initial
    begin
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd(ADDR_GENERAL_STATUS, 16'h0000);
        rd(ADDR_ALERT_SUMMARY, 16'h0000);
        rd(ADDR_OV_ALERT, 16'h0000);
        $display("test reset done");
        t_cells;
        t_aux;
        t_reset;
        end_of_test;
    end

    initial
    begin
        #200000;
        failures++;
        end_of_test;
    end
endmodule
`default_nettype wire
